/* design/gpio_lcd_defs.vh */
/*
 Register offsets, field widths and reset values for the two
 multi-function GPIO / LCD segment ports.
 Assumes APB byte addressing; every register is one aligned word.
*/
`ifndef GPIO_LCD_DEFS_VH
`define GPIO_LCD_DEFS_VH

// Printed offsets (register index); byte address is four times this
`define UPPER_OUT_LATCH_IDX     12'h007
`define UPPER_DIRECTION_IDX     12'h00d
`define LOWER_DIRECTION_IDX     12'h024
`define UPPER_SEG_SELECT_IDX    12'hfa0
`define LOWER_SEG_SELECT_IDX    12'hfa1
// No printed offset for the lower latch; chosen index
`define LOWER_OUT_LATCH_IDX     12'h008

`define ADDR_W                  14
`define PORT_W                  8
`define PORT_RESET              8'h00

`endif

/* design/pin_sync2.v */
/*
 Two-flop synchroniser for a bus of pin levels.
 Assumes inputs arrive asynchronously to core_clk_i.
*/
`timescale 1ns/10ps
module pin_sync2 #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             core_clk_i,
    input  wire             sys_rst_i,
    // Data
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta_r;

always @(posedge core_clk_i)
begin
    if (sys_rst_i)
    begin
        meta_r <= {WIDTH{1'b0}};
        sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= async_i;
        sync_o <= meta_r;
    end
end

endmodule // pin_sync2

/* design/port_pin_ctrl.v */
/*
 Per-pin function select for one 8-bit multi-function port:
 input, driven output, or LCD segment line. Registered pin outputs; read view is combinational.
 Assumes synchronised pin levels and segment levels on core_clk_i.
*/
`timescale 1ns/10ps
module port_pin_ctrl #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             core_clk_i,
    input  wire             sys_rst_i,
    // Control
    input  wire [WIDTH-1:0] out_latch_i,
    input  wire [WIDTH-1:0] direction_i,
    input  wire [WIDTH-1:0] seg_select_i,
    input  wire [WIDTH-1:0] seg_level_i,
    input  wire [WIDTH-1:0] pin_sync_i,
    // Pins
    output reg  [WIDTH-1:0] pin_out_o,
    output reg  [WIDTH-1:0] pin_oe_o,
    // Read view
    output wire [WIDTH-1:0] read_data_o
);

// Input bits read pin, segment-only bits read 0, output bits the latch
assign read_data_o = (direction_i & out_latch_i)
                   | (~direction_i & ~seg_select_i
                      & pin_sync_i);

always @(posedge core_clk_i)
begin
    if (sys_rst_i)
    begin
        pin_out_o <= {WIDTH{1'b0}};
        pin_oe_o  <= {WIDTH{1'b0}};
    end
    else
    begin
        pin_oe_o  <= seg_select_i | direction_i;
        pin_out_o <= (seg_select_i & seg_level_i)
                   | (~seg_select_i & out_latch_i);
    end
end

endmodule // port_pin_ctrl

/* design/dual_gpio_lcd_ports.v */
/*
 Two 8-bit GPIO ports whose pins double as LCD segment lines,
 with latch, direction and segment-select registers on APB.
 Assumes a single 10 MHz core clock, synchronous active-high reset,
 and an external LCD driver supplying segment levels.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`include "gpio_lcd_defs.vh"
module dual_gpio_lcd_ports (
    // Clock and reset
    input  wire                core_clk_i,
    input  wire                sys_rst_i,
    // APB slave
    input  wire                psel_i,
    input  wire                penable_i,
    input  wire                pwrite_i,
    input  wire [`ADDR_W-1:0]  paddr_i,
    input  wire [31:0]         pwdata_i,
    input  wire [3:0]          pstrb_i,
    output reg  [31:0]         prdata_o,
    output reg                 pready_o,
    output reg                 pslverr_o,
    // LCD segment levels, line n at index n
    input  wire [15:0]         lcd_segment_i,
    // Upper port pins
    input  wire [`PORT_W-1:0]  upper_port_pin_i,
    output wire [`PORT_W-1:0]  upper_port_pin_o,
    output wire [`PORT_W-1:0]  upper_port_pin_oe_o,
    // Lower port pins
    input  wire [`PORT_W-1:0]  lower_port_pin_i,
    output wire [`PORT_W-1:0]  lower_port_pin_o,
    output wire [`PORT_W-1:0]  lower_port_pin_oe_o
);

function [`ADDR_W-1:0] byte_addr;
    input [11:0] idx;
    begin
        byte_addr = {idx, 2'b00};
    end
endfunction

// Reverse bit order: port bit 7 is the lowest segment line
function [`PORT_W-1:0] rev8;
    input [`PORT_W-1:0] v;
    integer k;
    begin
        for (k = 0; k < `PORT_W; k = k + 1)
            rev8[k] = v[`PORT_W-1-k];
    end
endfunction

reg  [`PORT_W-1:0] upper_port_out_latch_r;
reg  [`PORT_W-1:0] upper_port_direction_r;
reg  [`PORT_W-1:0] upper_port_segment_select_r;
reg  [`PORT_W-1:0] lower_port_out_latch_r;
reg  [`PORT_W-1:0] lower_port_direction_r;
reg  [`PORT_W-1:0] lower_port_segment_select_r;

wire [`PORT_W-1:0] upper_sync;
wire [`PORT_W-1:0] lower_sync;
wire [`PORT_W-1:0] upper_read;
wire [`PORT_W-1:0] lower_read;
wire [15:0]        seg_sync;

wire access_ph = psel_i & penable_i & ~pready_o;
wire wr_en     = access_ph & pwrite_i & pstrb_i[0];

wire hit_uo = (paddr_i == byte_addr(`UPPER_OUT_LATCH_IDX));
wire hit_ud = (paddr_i == byte_addr(`UPPER_DIRECTION_IDX));
wire hit_us = (paddr_i == byte_addr(`UPPER_SEG_SELECT_IDX));
wire hit_lo = (paddr_i == byte_addr(`LOWER_OUT_LATCH_IDX));
wire hit_ld = (paddr_i == byte_addr(`LOWER_DIRECTION_IDX));
wire hit_ls = (paddr_i == byte_addr(`LOWER_SEG_SELECT_IDX));
wire hit_any = hit_uo | hit_ud | hit_us | hit_lo | hit_ld | hit_ls;

reg [`PORT_W-1:0] rd_nxt;

always @*
begin
    rd_nxt = `PORT_RESET;
    if (hit_uo)
        rd_nxt = upper_read;
    else if (hit_lo)
        rd_nxt = lower_read;
    else if (hit_ud)
        rd_nxt = upper_port_direction_r;
    else if (hit_us)
        rd_nxt = upper_port_segment_select_r;
    else if (hit_ld)
        rd_nxt = lower_port_direction_r;
    else if (hit_ls)
        rd_nxt = lower_port_segment_select_r;
end

always @(posedge core_clk_i)
begin
    if (sys_rst_i)
    begin
        upper_port_out_latch_r      <= `PORT_RESET;
        upper_port_direction_r      <= `PORT_RESET;
        upper_port_segment_select_r <= `PORT_RESET;
        lower_port_out_latch_r      <= `PORT_RESET;
        lower_port_direction_r      <= `PORT_RESET;
        lower_port_segment_select_r <= `PORT_RESET;
    end
    else if (wr_en)
    begin
        if (hit_uo)
            upper_port_out_latch_r <= pwdata_i[`PORT_W-1:0];
        if (hit_lo)
            lower_port_out_latch_r <= pwdata_i[`PORT_W-1:0];
        if (hit_ud)
            upper_port_direction_r <= pwdata_i[`PORT_W-1:0];
        if (hit_us)
            upper_port_segment_select_r <= pwdata_i[`PORT_W-1:0];
        if (hit_ld)
            lower_port_direction_r <= pwdata_i[`PORT_W-1:0];
        if (hit_ls)
            lower_port_segment_select_r <= pwdata_i[`PORT_W-1:0];
    end
end

// One wait state: answer registered in the access phase
always @(posedge core_clk_i)
begin
    if (sys_rst_i)
    begin
        pready_o  <= 1'b0;
        pslverr_o <= 1'b0;
        prdata_o  <= 32'h00000000;
    end
    else
    begin
        pready_o  <= access_ph;
        pslverr_o <= access_ph & ~hit_any;
        if (access_ph & ~pwrite_i)
            prdata_o <= {24'h000000, rd_nxt};
        else
            prdata_o <= 32'h00000000;
    end
end

pin_sync2 #(.WIDTH(`PORT_W)) u_sync_upper (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (upper_port_pin_i),
    .sync_o     (upper_sync)
);

pin_sync2 #(.WIDTH(`PORT_W)) u_sync_lower (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (lower_port_pin_i),
    .sync_o     (lower_sync)
);

pin_sync2 #(.WIDTH(16)) u_sync_seg (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (lcd_segment_i),
    .sync_o     (seg_sync)
);

port_pin_ctrl #(.WIDTH(`PORT_W)) u_upper (
    .core_clk_i   (core_clk_i),
    .sys_rst_i    (sys_rst_i),
    .out_latch_i  (upper_port_out_latch_r),
    .direction_i  (upper_port_direction_r),
    .seg_select_i (upper_port_segment_select_r),
    .seg_level_i  (rev8(seg_sync[15:8])),
    .pin_sync_i   (upper_sync),
    .pin_out_o    (upper_port_pin_o),
    .pin_oe_o     (upper_port_pin_oe_o),
    .read_data_o  (upper_read)
);

port_pin_ctrl #(.WIDTH(`PORT_W)) u_lower (
    .core_clk_i   (core_clk_i),
    .sys_rst_i    (sys_rst_i),
    .out_latch_i  (lower_port_out_latch_r),
    .direction_i  (lower_port_direction_r),
    .seg_select_i (lower_port_segment_select_r),
    .seg_level_i  (rev8(seg_sync[7:0])),
    .pin_sync_i   (lower_sync),
    .pin_out_o    (lower_port_pin_o),
    .pin_oe_o     (lower_port_pin_oe_o),
    .read_data_o  (lower_read)
);

endmodule // dual_gpio_lcd_ports

/* testbench/dual_gpio_lcd_ports_properties.sv */
/* Port checker for dual_gpio_lcd_ports.
   Assumes sync active-high reset on core_clk_i. */
`timescale 1ns/10ps
module gpio_lcd_ports_chk (
    input wire        core_clk_i, sys_rst_i, psel_i, penable_i,
    input wire        pwrite_i, pready_o, pslverr_o,
    input wire [13:0] paddr_i,
    input wire [31:0] prdata_o,
    input wire [7:0]  lower_port_pin_o, lower_port_pin_oe_o,
    input wire [7:0]  upper_port_pin_o, upper_port_pin_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_reset_clears_pins: assert property ($fell(sys_rst_i) |->
        (lower_port_pin_oe_o | upper_port_pin_oe_o | lower_port_pin_o
         | upper_port_pin_o) == 8'h00) else $error("pins not idle");
    a_one_wait: assert property (psel_i && penable_i && !pready_o |=>
        pready_o) else $error("no answer");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    a_err_data_zero: assert property (pready_o && pslverr_o |->
        prdata_o == 32'h0) else $error("error data");
    a_upper_bits_zero: assert property (pready_o |->
        prdata_o[31:8] == 24'h0) else $error("upper bits");
    a_unmapped_err: assert property (pready_o && paddr_i == 14'h0004 |->
        pslverr_o) else $error("no error");
    a_mapped_ok: assert property (pready_o && paddr_i == 14'h0090 |->
        !pslverr_o) else $error("false error");
    a_oe_by_write: assert property (!$past(sys_rst_i) &&
        $changed(lower_port_pin_oe_o) |-> $past(pready_o && pwrite_i))
        else $error("oe moved");
    c_write: cover property (pready_o && pwrite_i);
    c_read: cover property (pready_o && !pwrite_i);
    c_err: cover property (pready_o && pslverr_o);
endmodule // gpio_lcd_ports_chk
bind dual_gpio_lcd_ports gpio_lcd_ports_chk chk_u (.*);

/* testbench/pin_side_model.sv */
/* Outside pin circuitry: resolves one port's pin levels.
   Assumes undriven pins follow an outside source. */
`timescale 1ns/10ps
module pin_side_model (
    input  wire [7:0] pin_drive_i, pin_oe_i, ext_level_i,
    output wire [7:0] pin_level_o
);
    assign pin_level_o = (pin_oe_i & pin_drive_i) | (~pin_oe_i & ext_level_i);
endmodule // pin_side_model

/* testbench/tb_dual_gpio_lcd_segment_ports.sv */
/* Self-checking bench for dual_gpio_lcd_ports.
   Assumes APB with one wait state and 2-flop pin sync. */
`timescale 1ns/10ps
module tb_dual_gpio_lcd_segment_ports;
    reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    reg [13:0] paddr = 14'h0;
    reg [31:0] pwdata = 32'h0;
    reg [3:0] pstrb = 4'h0;
    reg [15:0] seg = 16'h0;
    reg [7:0] ext [0:1], l, d, s, sp;
    wire [31:0] prdata;
    wire rdy, err;
    wire [7:0] lo_o, lo_oe, lo_i, up_o, up_oe, up_i;
    reg [32:0] q [$];
    reg [13:0] lat [0:1], dir [0:1], sel [0:1];
    integer num_errors = 0, n_compared = 0, cyc = 0, p, i;
    integer seed = 32'h35e1fdcc;
    dual_gpio_lcd_ports dut_u (.core_clk_i(clk), .sys_rst_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(rdy), .pslverr_o(err),
        .lcd_segment_i(seg), .upper_port_pin_i(up_i),
        .upper_port_pin_o(up_o), .upper_port_pin_oe_o(up_oe),
        .lower_port_pin_i(lo_i), .lower_port_pin_o(lo_o),
        .lower_port_pin_oe_o(lo_oe));
    pin_side_model lo_u (.pin_drive_i(lo_o), .pin_oe_i(lo_oe),
        .ext_level_i(ext[0]), .pin_level_o(lo_i));
    pin_side_model up_u (.pin_drive_i(up_o), .pin_oe_i(up_oe),
        .ext_level_i(ext[1]), .pin_level_o(up_i));
    initial forever #50 clk = ~clk;
    function [7:0] rev8(input [7:0] x);
        integer j;
        for (j = 0; j < 8; j = j + 1) rev8[j] = x[7-j];
    endfunction
    task complete_run;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input [32:0] got, input [32:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input w, input [13:0] a, input [31:0] dt, input [3:0] st);
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= dt; pstrb <= st;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        psel <= 0; penable <= 0;
    endtask
    task rd(input [13:0] a, input [32:0] e);
        q.push_back(e);
        apb(0, a, 32'h0, 4'h0);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            complete_run;
        end
        if (rdy === 1'b1 && !pwrite)
            chk({err, prdata}, q.pop_front());
    end
    initial
    begin
        lat[0] = 14'h0020; dir[0] = 14'h0090; sel[0] = 14'h3e84;
        lat[1] = 14'h001c; dir[1] = 14'h0034; sel[1] = 14'h3e80;
        ext[0] = $random(seed); ext[1] = $random(seed);
        seg <= $random(seed);
        repeat (20) @(posedge clk);
        rst <= 0;
        for (p = 0; p < 2; p = p + 1)
        begin
            rd(dir[p], 33'h0);
            rd(sel[p], 33'h0);
            rd(lat[p], {25'h0, ext[p]});
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            p = i % 2;
            l = $random(seed); d = $random(seed); s = $random(seed);
            apb(1, lat[p], {24'h0, l}, 4'hf);
            apb(1, dir[p], {24'h0, d}, 4'hf);
            apb(1, sel[p], {24'h0, s}, 4'hf);
            repeat (5) @(posedge clk);
            rd(dir[p], {25'h0, d});
            rd(sel[p], {25'h0, s});
            rd(lat[p], {25'h0, (d & l) | (~d & ~s & ext[p])});
            sp = p ? rev8(seg[15:8]) : rev8(seg[7:0]);
            chk(p ? up_oe : lo_oe, d | s);
            chk(p ? up_o : lo_o, (s & sp) | (~s & l));
        end
        apb(1, sel[0], 32'h0, 4'hf);
        apb(1, dir[0], 32'h0, 4'hf);
        apb(1, lat[0], 32'h5a, 4'hf);
        apb(1, dir[0], 32'hff, 4'hf);
        apb(1, lat[0], 32'h11, 4'h0);
        repeat (5) @(posedge clk);
        chk(lo_o, 33'h5a);
        rd(lat[0], 33'h5a);
        apb(1, dir[0], 32'hf0, 4'hf);
        rd(lat[0], {25'h0, 8'h50 | (ext[0] & 8'h0f)});
        apb(1, lat[0], {24'h0, 8'h50 | (ext[0] & 8'h0f)}, 4'hf);
        apb(1, dir[0], 32'hff, 4'hf);
        repeat (5) @(posedge clk);
        chk(lo_o, {25'h0, 8'h50 | (ext[0] & 8'h0f)});
        rd(14'h0004, {1'b1, 32'h0});
        repeat (3) @(posedge clk);
        complete_run;
    end
endmodule // tb_dual_gpio_lcd_segment_ports
